/* lwid_pkg.sv */
/*
 * shared constants and carrier types for the local wake input detector.
 * assumes a 40 MHz core clock; times are given in microseconds or in 100 us ticks.
 */
package lwid_pkg;

   // ==========================================================
   // clock and time base
   localparam int CLK_KHZ = 40000;
   localparam int US_CYCLES = CLK_KHZ / 1000;
   // one tick every 100 us keeps the width counters narrow
   localparam int TICK_US = 100;
   localparam int TICK_CYCLES = TICK_US * US_CYCLES;

   // ==========================================================
   // timing constants in ticks of 100 us
   localparam int WAKE_SETTLE_US = 1000;
   localparam logic [15:0] WAKE_SETTLE_TICKS =
      16'((WAKE_SETTLE_US + TICK_US - 1) / TICK_US);
   localparam logic [15:0] REJECT_5MS_TICKS = 16'h0032;
   localparam logic [15:0] MAX_750MS_TICKS = 16'h1d4c;
   localparam logic [15:0] MAX_1000MS_TICKS = 16'h2710;
   localparam logic [15:0] MAX_1500MS_TICKS = 16'h3a98;
   localparam logic [15:0] MAX_2000MS_TICKS = 16'h4e20;
   // on-time sampling window choices, in ticks
   localparam logic [15:0] CYC_WIN_SHORT_TICKS = 16'h0001;
   localparam logic [15:0] CYC_WIN_LONG_TICKS = 16'h0005;
   // switch timer fields: period code in [7:4], on-time code in [3:0]
   localparam int TMR_PER_MSB = 7;
   localparam int TMR_PER_LSB = 4;
   localparam int TMR_ON_MSB = 3;
   localparam int TMR_ON_LSB = 0;
   // ticks per period step and per on-time step
   localparam logic [15:0] TMR_PER_STEP_TICKS = 16'h0064;
   localparam logic [15:0] TMR_ON_STEP_TICKS = 16'h0001;

   // ==========================================================
   // field encodings and reset values
   localparam logic [1:0] EDGE_BOTH = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_PULSE = 2'h3;
   localparam logic [1:0] STAT_NONE = 2'h0;
   localparam logic [1:0] STAT_RISE = 2'h1;
   localparam logic [1:0] STAT_FALL = 2'h2;
   localparam logic [1:0] REJECT_RESET = 2'h1;

   // ==========================================================
   // device operating modes
   typedef enum logic [5:0] {
      LWID_MODE_SLEEP = 6'h01,
      LWID_MODE_STANDBY = 6'h02,
      LWID_MODE_FAILSAFE = 6'h04,
      LWID_MODE_NORMAL = 6'h08,
      LWID_MODE_FAST = 6'h10,
      LWID_MODE_RESTART = 6'h20
   } lwid_mode_t;

   // configuration carried as one bundle
   typedef struct packed {
      logic [1:0] edge_sel;
      logic [1:0] reject_sel;
      logic [1:0] max_sel;
      logic pulse_upper_limit_disable;
      logic pulse_polarity;
      logic cyclic_enable;
      logic cyclic_timer_sel;
      logic cyclic_window_long;
      logic [7:0] timer1;
      logic [7:0] timer2;
      logic serial_control;
   } lwid_cfg_t;

   // supply and enable qualifiers for the standby move
   typedef struct packed {
      logic regulator_ok;
      logic reset_release_done;
      logic enable_qualified;
   } lwid_qual_t;

endpackage : lwid_pkg

/* lwid_sync.sv */
/*
 * three-flop input synchroniser with agreement filter.
 * assumes the input is asynchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module lwid_sync (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic async_i,
   output logic level_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_next;

   // the level only moves once stages two and three agree
   assign level_next = (s2_reg == s3_reg) ? s3_reg : level_o;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_o <= level_next;
      end
   end
endmodule : lwid_sync
`default_nettype wire

/* lwid_tick.sv */
/*
 * free running divider giving a one-cycle tick every period.
 * assumes a single clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module lwid_tick #(
   parameter int PERIOD = 4000
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   output logic tick_o
);
   localparam logic [15:0] LAST = 16'(PERIOD - 1);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic wrap;

   assign wrap = (cnt_reg == LAST);
   assign cnt_next = wrap ? 16'h0000 : cnt_reg + 16'h0001;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cnt_reg <= 16'h0000;
         tick_o <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_o <= wrap;
      end
   end
endmodule : lwid_tick
`default_nettype wire

/* lwid_detector.sv */
/*
 * local wake input detector: static edge, pulse, filtered and
 * cyclic-sense wake qualification, sticky edge status.
 * assumes the mode input comes from the device mode controller on clk_i,
 * the wake input is an asynchronous comparator output, and software
 * clears status by a one-cycle write strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module lwid_detector #(
   // clock cycles per tick; every width and period scales with it
   parameter int TICK_PERIOD = lwid_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wake_i,
   input wire lwid_pkg::lwid_mode_t mode_i,
   input wire lwid_pkg::lwid_cfg_t cfg_i,
   input wire lwid_pkg::lwid_qual_t qual_i,
   input wire logic stat_write_i,
   input wire logic [1:0] stat_wdata_i,
   output logic local_wakeup_event_o,
   output logic restart_req_o,
   output logic standby_req_o,
   output logic inhibit_out_o,
   output logic interrupt_o,
   output logic rxd_low_o,
   output logic high_side_switch_out_o,
   output logic sense_power_o,
   output logic cyclic_active_o,
   output logic [1:0] wake_stat_o
);

   // ==========================================================
   // synchronisation and time base
   logic wake_s;
   logic tick;

   lwid_sync u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .async_i(wake_i),
      .level_o(wake_s)
   );

   lwid_tick #(
      .PERIOD(TICK_PERIOD)
   ) u_tick (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_o(tick)
   );

   // ==========================================================
   // mode decode
   logic armed;
   logic in_sleep;
   logic in_standby;
   logic in_failsafe;
   logic mode_changed;
   lwid_pkg::lwid_mode_t mode_reg;

   assign in_sleep = (mode_i == lwid_pkg::LWID_MODE_SLEEP);
   assign in_standby = (mode_i == lwid_pkg::LWID_MODE_STANDBY);
   assign in_failsafe = (mode_i == lwid_pkg::LWID_MODE_FAILSAFE);
   assign armed = in_sleep | in_standby | in_failsafe;
   // mode_reg resets to restart, so leaving reset reads as an entry
   assign mode_changed = (mode_i != mode_reg);

   // ==========================================================
   // width thresholds
   logic [15:0] reject_ticks;
   logic [15:0] min_ticks;
   logic [15:0] max_ticks;

   // reject doubles per step; minimum is twice the reject width
   assign reject_ticks =
      lwid_pkg::REJECT_5MS_TICKS << cfg_i.reject_sel;
   assign min_ticks = reject_ticks << 1;

   always_comb begin
      unique case (cfg_i.max_sel)
         2'h0: max_ticks = lwid_pkg::MAX_750MS_TICKS;
         2'h1: max_ticks = lwid_pkg::MAX_1000MS_TICKS;
         2'h2: max_ticks = lwid_pkg::MAX_1500MS_TICKS;
         2'h3: max_ticks = lwid_pkg::MAX_2000MS_TICKS;
      endcase
   end

   // ==========================================================
   // static path: settle, edge and width measurement
   logic prev_reg;
   logic settled_reg;
   logic [15:0] settle_reg;
   logic [15:0] width_reg;
   logic in_pulse_reg;
   logic rise;
   logic fall;
   logic active_lvl;
   logic edge_ok;
   logic pulse_start;
   logic pulse_end;
   logic width_valid;
   logic static_wake;
   logic filter_wake;
   logic pulse_mode;
   logic cyc_sel;

   // fail-safe has the switch off, so sensing is static there
   assign cyc_sel = cfg_i.cyclic_enable & cfg_i.serial_control
                  & ~in_failsafe;
   assign rise = wake_s & ~prev_reg;
   assign fall = ~wake_s & prev_reg;
   assign pulse_mode = (cfg_i.edge_sel == lwid_pkg::EDGE_PULSE);
   // polarity 0 means low-high-low, so the pulse level is high
   assign active_lvl = ~cfg_i.pulse_polarity;
   assign pulse_start = active_lvl ? rise : fall;
   assign pulse_end = active_lvl ? fall : rise;

   always_comb begin
      unique case (cfg_i.edge_sel)
         lwid_pkg::EDGE_BOTH: edge_ok = rise | fall;
         lwid_pkg::EDGE_RISE: edge_ok = rise;
         lwid_pkg::EDGE_FALL: edge_ok = fall;
         lwid_pkg::EDGE_PULSE: edge_ok = 1'b0;
      endcase
   end

   // a pulse counts when it ends between minimum and maximum width
   assign width_valid = in_pulse_reg & pulse_end
                      & (width_reg >= min_ticks)
                      & (cfg_i.pulse_upper_limit_disable
                         | (width_reg <= max_ticks));
   // filtered: accept as soon as the active level exceeds minimum
   assign filter_wake = pulse_mode & cfg_i.pulse_upper_limit_disable
                      & in_pulse_reg & (width_reg > min_ticks)
                      & tick;

   logic edge_pend_reg;
   logic edge_wake;
   // the level after the edge must outlast the reject width
   assign edge_wake = edge_pend_reg & tick
                    & (width_reg >= reject_ticks);

   assign static_wake = settled_reg & ~cyc_sel
      & (edge_wake
         | (pulse_mode & ~cfg_i.pulse_upper_limit_disable
            & width_valid)
         | filter_wake);

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         prev_reg <= 1'b0;
         settled_reg <= 1'b0;
         settle_reg <= 16'h0000;
         width_reg <= 16'h0000;
         in_pulse_reg <= 1'b0;
         edge_pend_reg <= 1'b0;
      end else begin
         prev_reg <= wake_s;
         // any change restarts the settle count on mode entry
         if (mode_changed || rise || fall) begin
            settle_reg <= 16'h0000;
         end else if (tick && !settled_reg) begin
            settle_reg <= settle_reg + 16'h0001;
         end
         if (mode_changed && !armed) begin
            settled_reg <= 1'b0;
         end else if (mode_changed) begin
            settled_reg <= 1'b0;
         end else if (settle_reg >= lwid_pkg::WAKE_SETTLE_TICKS) begin
            settled_reg <= 1'b1;
         end
         if (rise || fall) begin
            width_reg <= 16'h0000;
         end else if (tick && width_reg != 16'hffff) begin
            width_reg <= width_reg + 16'h0001;
         end
         // a pulse under way at entry, or begun unsettled, is not
         // measured; it would be timed from the wrong start
         if (mode_changed) begin
            in_pulse_reg <= 1'b0;
         end else if (pulse_start && settled_reg) begin
            in_pulse_reg <= 1'b1;
         end else if (pulse_end || filter_wake) begin
            in_pulse_reg <= 1'b0;
         end
         // an edge from before entry or while disarmed is void
         if (mode_changed || !armed) begin
            edge_pend_reg <= 1'b0;
         end else if (edge_ok && settled_reg) begin
            edge_pend_reg <= 1'b1;
         end else if (rise || fall || edge_wake) begin
            edge_pend_reg <= 1'b0; // short glitch dropped
         end
      end
   end

   // ==========================================================
   // cyclic sensing: switch strobe and sample compare
   logic [7:0] tmr;
   logic [15:0] per_ticks;
   logic [15:0] on_ticks;
   logic [15:0] win_ticks;
   logic [15:0] cyc_cnt_reg;
   logic ref_valid_reg;
   logic ref_reg;
   logic sample_now;
   logic cyc_change;
   logic hss_on;

   assign tmr = cfg_i.cyclic_timer_sel ? cfg_i.timer2 : cfg_i.timer1;
   assign per_ticks = 16'(({8'h00, 4'h0, tmr[lwid_pkg::TMR_PER_MSB:
      lwid_pkg::TMR_PER_LSB]} + 16'h0001)
      * lwid_pkg::TMR_PER_STEP_TICKS);
   assign on_ticks = 16'(({8'h00, 4'h0, tmr[lwid_pkg::TMR_ON_MSB:
      lwid_pkg::TMR_ON_LSB]} + 16'h0001)
      * lwid_pkg::TMR_ON_STEP_TICKS);
   assign win_ticks = cfg_i.cyclic_window_long
                    ? lwid_pkg::CYC_WIN_LONG_TICKS
                    : lwid_pkg::CYC_WIN_SHORT_TICKS;
   assign hss_on = cyc_sel & (in_sleep | in_standby)
                 & (cyc_cnt_reg < on_ticks);
   // the first window after entry may be cut short by the tick phase;
   // that sample only becomes the reference, so no false wake follows
   // sample at the end of the window, clipped to the on time
   assign sample_now = hss_on & tick
      & ((cyc_cnt_reg + 16'h0001 == win_ticks)
         | (cyc_cnt_reg + 16'h0001 == on_ticks)
           & (win_ticks > on_ticks));
   assign cyc_change = sample_now & ref_valid_reg
                     & (wake_s != ref_reg);

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cyc_cnt_reg <= 16'h0000;
         ref_valid_reg <= 1'b0;
         ref_reg <= 1'b0;
      end else begin
         if (mode_changed || !cyc_sel) begin
            cyc_cnt_reg <= 16'h0000;
            ref_valid_reg <= 1'b0;
         end else if (tick) begin
            cyc_cnt_reg <= (cyc_cnt_reg + 16'h0001 >= per_ticks)
                         ? 16'h0000 : cyc_cnt_reg + 16'h0001;
         end
         if (sample_now && !mode_changed) begin
            ref_reg <= wake_s;
            ref_valid_reg <= 1'b1; // first sample is only reference
         end
      end
   end

   // ==========================================================
   // outputs and status
   logic wake_ev;
   logic [1:0] stat_next;
   logic std_pending_reg;
   logic std_ok;

   assign wake_ev = armed & (static_wake
      | (cyc_change & in_sleep));
   // a new edge beats a clear in the same cycle
   assign stat_next = (armed && rise) ? lwid_pkg::STAT_RISE
                    : (armed && fall) ? lwid_pkg::STAT_FALL
                    : (stat_write_i && stat_wdata_i == 2'h0)
                      ? lwid_pkg::STAT_NONE : wake_stat_o;
   // pin control also needs the enable pin qualified
   assign std_ok = qual_i.regulator_ok & qual_i.reset_release_done
      & (cfg_i.serial_control | qual_i.enable_qualified);

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         local_wakeup_event_o <= 1'b0;
         restart_req_o <= 1'b0;
         standby_req_o <= 1'b0;
         inhibit_out_o <= 1'b0;
         interrupt_o <= 1'b0;
         rxd_low_o <= 1'b0;
         high_side_switch_out_o <= 1'b0;
         sense_power_o <= 1'b1;
         cyclic_active_o <= 1'b0;
         wake_stat_o <= lwid_pkg::STAT_NONE;
         mode_reg <= lwid_pkg::LWID_MODE_RESTART;
         std_pending_reg <= 1'b0;
      end else begin
         mode_reg <= mode_i;
         // status stays clear at power-up while the pull-down holds the pin low
         wake_stat_o <= stat_next;
         local_wakeup_event_o <= wake_ev;
         restart_req_o <= wake_ev & ~in_standby;
         interrupt_o <= cyc_change & in_standby;
         if (cyc_change && in_standby) begin
            rxd_low_o <= 1'b1;
         end else if (!armed) begin
            rxd_low_o <= 1'b0;
         end
         if (filter_wake && armed) begin
            inhibit_out_o <= 1'b1;
         end else if (!armed) begin
            inhibit_out_o <= 1'b0;
         end
         if (wake_ev) begin
            std_pending_reg <= 1'b1;
         end else if (standby_req_o) begin
            std_pending_reg <= 1'b0;
         end
         standby_req_o <= std_pending_reg & std_ok & ~standby_req_o;
         high_side_switch_out_o <= hss_on;
         // sense circuit only powered during on time in cyclic sleep
         sense_power_o <= ~(cyc_sel & in_sleep) | hss_on;
         cyclic_active_o <= cyc_sel;
      end
   end

endmodule : lwid_detector
`default_nettype wire

/* lwid_wake_switch.sv */
/*
 * model of the external switch wired from the high-side output to WAKE.
 * assumes the bench moves closed_i just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module lwid_wake_switch (
   input wire logic closed_i,
   input wire logic hss_i,
   input wire logic cyclic_i,
   output logic wake_o
);
   // ==========================================================
   // wire level
   // an open switch leaves the pin on the internal pull-down
   // under cyclic sensing the switch only sees supply in on time
   assign wake_o = closed_i & (cyclic_i ? hss_i : 1'b1);
endmodule : lwid_wake_switch
`default_nettype wire

/* lwid_detector_chk.sv */
/*
 * concurrent checks on the ports of the local wake input detector.
 * assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module lwid_detector_chk (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wake_i,
   input wire lwid_pkg::lwid_mode_t mode_i,
   input wire lwid_pkg::lwid_cfg_t cfg_i,
   input wire lwid_pkg::lwid_qual_t qual_i,
   input wire logic stat_write_i,
   input wire logic [1:0] stat_wdata_i,
   input wire logic local_wakeup_event_o,
   input wire logic restart_req_o,
   input wire logic standby_req_o,
   input wire logic inhibit_out_o,
   input wire logic interrupt_o,
   input wire logic rxd_low_o,
   input wire logic high_side_switch_out_o,
   input wire logic sense_power_o,
   input wire logic cyclic_active_o,
   input wire logic [1:0] wake_stat_o
);
   // ==========================================================
   // helpers
   // cycles since wake_i last moved, saturating at 15
   logic [3:0] quiet_reg;
   logic [3:0] quiet_next;
   logic last_wake_reg;
   logic disarmed;
   logic sleep_cyc_off;
   assign quiet_next = (wake_i != last_wake_reg) ? 4'h0 :
      ((quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1);
   assign disarmed = mode_i inside {lwid_pkg::LWID_MODE_NORMAL,
      lwid_pkg::LWID_MODE_FAST, lwid_pkg::LWID_MODE_RESTART};
   assign sleep_cyc_off = (mode_i == lwid_pkg::LWID_MODE_SLEEP) &&
      cyclic_active_o && !high_side_switch_out_o;
   always_ff @(posedge clk_i) begin
      quiet_reg <= rstn_i ? quiet_next : 4'h0;
      last_wake_reg <= rstn_i ? wake_i : 1'b0;
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_disarm_quiet: assert property ((disarmed)[*3] |-> !local_wakeup_event_o
      && !restart_req_o && !inhibit_out_o && !rxd_low_o)
      else $error("wake activity while disarmed");
   a_event_single: assert property (local_wakeup_event_o |=> !local_wakeup_event_o)
      else $error("wake event longer than one cycle");
   a_restart_event: assert property (restart_req_o |-> local_wakeup_event_o)
      else $error("restart request without wake event");
   a_stat_code: assert property (wake_stat_o != 2'h3)
      else $error("status holds an unused code");
   a_stat_cause: assert property (($changed(wake_stat_o) &&
      wake_stat_o != lwid_pkg::STAT_NONE) |-> quiet_reg < 4'ha)
      else $error("status set without a wake change");
   a_stat_clear: assert property ((stat_write_i && stat_wdata_i == 2'h0 &&
      quiet_reg == 4'hf) |=> wake_stat_o == lwid_pkg::STAT_NONE)
      else $error("status not cleared by zero write");
   a_pin_static: assert property ((!cfg_i.serial_control)[*3] |-> !cyclic_active_o)
      else $error("cyclic sensing under pin control");
   a_fs_static: assert property ((mode_i == lwid_pkg::LWID_MODE_FAILSAFE)[*3]
      |-> !cyclic_active_o && !high_side_switch_out_o)
      else $error("cyclic sensing kept in fail-safe");
   a_sense_gate: assert property ((sleep_cyc_off)[*3] |-> !$past(sense_power_o))
      else $error("sense powered outside on time");
   a_standby_qual: assert property (standby_req_o |->
      $past(qual_i.regulator_ok) && $past(qual_i.reset_release_done) &&
      ($past(cfg_i.serial_control) || $past(qual_i.enable_qualified)))
      else $error("standby request without qualifiers");
   a_irq_rxd: assert property (interrupt_o |-> rxd_low_o)
      else $error("interrupt without receive low");
endmodule : lwid_detector_chk
`default_nettype wire

/* tb_lwid_detector.sv */
/*
 * self-checking bench for the local wake input detector.
 * assumes a 40 MHz clock and the switch model on the WAKE pin.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_lwid_detector;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic closed = 1'b0;
   logic wake;
   lwid_pkg::lwid_mode_t mode = lwid_pkg::LWID_MODE_STANDBY;
   lwid_pkg::lwid_cfg_t cfg;
   lwid_pkg::lwid_qual_t qual = 3'h7;
   logic stat_write = 1'b0;
   logic [1:0] stat_wdata = 2'h0;
   logic [1:0] exp_st = 2'h0;
   logic ev, rs, sb, inhibit_out, irq, rxl, high_side_switch_out, spw, cyc_act;
   logic [1:0] stat;
   int fails = 0;
   int checks = 0;
   int ev_cnt = 0;
   int rs_cnt = 0;
   int irq_cnt = 0;
   int sb_cnt = 0;
   int n, m, s;
   int lv_q[$];
   lwid_pkg::lwid_mode_t dis[3] = '{lwid_pkg::LWID_MODE_NORMAL,
      lwid_pkg::LWID_MODE_FAST, lwid_pkg::LWID_MODE_RESTART};

   always #12.5 clk_i = ~clk_i;

   lwid_wake_switch lwid_wake_switch_i (.closed_i(closed), .hss_i(high_side_switch_out),
      .cyclic_i(cyc_act), .wake_o(wake));
   // a 40-cycle tick scales every width and period down by 100
   lwid_detector #(.TICK_PERIOD(40)) lwid_detector_i (.clk_i(clk_i),
      .rstn_i(rstn_i), .wake_i(wake), .mode_i(mode), .cfg_i(cfg),
      .qual_i(qual),
      .stat_write_i(stat_write), .stat_wdata_i(stat_wdata),
      .local_wakeup_event_o(ev), .restart_req_o(rs), .standby_req_o(sb),
      .inhibit_out_o(inhibit_out), .interrupt_o(irq), .rxd_low_o(rxl),
      .high_side_switch_out_o(high_side_switch_out), .sense_power_o(spw),
      .cyclic_active_o(cyc_act), .wake_stat_o(stat));

   always @(posedge clk_i) begin
      if (ev === 1'b1) ev_cnt++;
      if (rs === 1'b1) rs_cnt++;
      if (irq === 1'b1) irq_cnt++;
      if (sb === 1'b1) sb_cnt++;
   end

   // ==========================================================
   // tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge clk_i);
   endtask : wait_cyc
   // the bench model keeps every level and the expected sticky status
   task automatic set_wake(input logic lv);
      @(posedge clk_i);
      closed <= lv;
      if (lv != lv_q[$]) exp_st = lv ? lwid_pkg::STAT_RISE : lwid_pkg::STAT_FALL;
      lv_q.push_back(lv);
   endtask : set_wake
   task automatic stat_wr(input logic [1:0] v);
      @(posedge clk_i);
      stat_write <= 1'b1;
      stat_wdata <= v;
      @(posedge clk_i);
      stat_write <= 1'b0;
      if (v == 2'h0) exp_st = lwid_pkg::STAT_NONE;
      @(negedge clk_i);
      check(stat, exp_st);
   endtask : stat_wr
   task automatic complete_run();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run

   // ==========================================================
   // main sequence
   initial begin
      cfg = '0;
      cfg.serial_control = 1'b1;
      lv_q.push_back(0);
      void'($urandom(32'h9221f952));
      wait_cyc(4);
      rstn_i <= 1'b1;
      wait_cyc(8);
      for (int i = 0; i < 4; i++) begin
         set_wake(~closed);
         wait_cyc(20 + $urandom % 20);
         @(negedge clk_i);
         check(stat, exp_st);
         stat_wr(i[0] ? 2'h0 : 2'(1 + $urandom % 3));
      end
      foreach (dis[k]) begin
         @(posedge clk_i);
         mode <= dis[k];
         n = ev_cnt;
         wait_cyc(600);
         set_wake(1'b1);
         wait_cyc(300);
         set_wake(1'b0);
         wait_cyc(2200);
         check(8'(ev_cnt - n), 8'h0);
      end
      // rising only: a level must not wake before the reject width, then wakes once with restart and standby
      @(posedge clk_i);
      cfg.edge_sel <= lwid_pkg::EDGE_RISE;
      mode <= lwid_pkg::LWID_MODE_SLEEP;
      wait_cyc(600);
      set_wake(1'b1);
      wait_cyc(20);
      set_wake(1'b0);
      wait_cyc(600);
      n = ev_cnt;
      m = rs_cnt;
      s = sb_cnt;
      set_wake(1'b1);
      wait_cyc(1960);
      check(8'(ev_cnt - n), 8'h0);
      for (int w = 0; w < 100 && ev_cnt == n; w++) wait_cyc(1);
      wait_cyc(2);
      check(8'(ev_cnt - n), 8'h1);
      check(8'(rs_cnt - m), 8'h1);
      check(8'(sb_cnt - s), 8'h1);
      @(posedge clk_i);
      mode <= lwid_pkg::LWID_MODE_RESTART;
      cfg.cyclic_enable <= 1'b1;
      wait_cyc(10);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i);
         cfg.serial_control <= (k != 1);
         mode <= (k == 2) ? lwid_pkg::LWID_MODE_FAILSAFE : lwid_pkg::LWID_MODE_SLEEP;
         wait_cyc(50);
         @(negedge clk_i);
         check(cyc_act, k == 0);
         if (k == 0) check(spw, high_side_switch_out);
      end
      // standby cyclic: a changed sample raises interrupt, receive low
      @(posedge clk_i);
      mode <= lwid_pkg::LWID_MODE_STANDBY;
      n = ev_cnt;
      m = irq_cnt;
      wait_cyc(200);
      set_wake(1'b0);
      wait_cyc(4200);
      @(negedge clk_i);
      check(8'(irq_cnt - m), 8'h1);
      check(rxl, 1'b1);
      check(8'(ev_cnt - n), 8'h0);
      // filtered pulse mode in sleep: a long high level sets inhibit
      @(posedge clk_i);
      mode <= lwid_pkg::LWID_MODE_SLEEP;
      cfg.cyclic_enable <= 1'b0;
      cfg.edge_sel <= lwid_pkg::EDGE_PULSE;
      cfg.pulse_upper_limit_disable <= 1'b1;
      wait_cyc(600);
      n = ev_cnt;
      set_wake(1'b1);
      for (int w = 0; w < 4200 && ev_cnt == n; w++) wait_cyc(1);
      wait_cyc(2);
      check(8'(ev_cnt - n), 8'h1);
      check(inhibit_out, 1'b1);
      complete_run();
   end

   // hang guard, well past the longest expected run
   initial begin
      wait_cyc(60000);
      fails++;
      complete_run();
   end
endmodule : tb_lwid_detector

bind lwid_detector lwid_detector_chk lwid_detector_chk_i (.clk_i(clk_i),
   .rstn_i(rstn_i), .wake_i(wake_i), .mode_i(mode_i), .cfg_i(cfg_i),
   .qual_i(qual_i), .stat_write_i(stat_write_i),
   .stat_wdata_i(stat_wdata_i), .local_wakeup_event_o(local_wakeup_event_o),
   .restart_req_o(restart_req_o), .standby_req_o(standby_req_o),
   .inhibit_out_o(inhibit_out_o), .interrupt_o(interrupt_o),
   .rxd_low_o(rxd_low_o), .high_side_switch_out_o(high_side_switch_out_o),
   .sense_power_o(sense_power_o), .cyclic_active_o(cyclic_active_o),
   .wake_stat_o(wake_stat_o));
`default_nettype wire
